// *** bench/host_model.sv ***
// host side model: apb master and ambient reading source
`timescale 1ns/1ps
module host_model (
  input  wire logic                  pclk,
  output logic                       psel,
  output logic                       penable,
  output logic                       pwrite,
  output logic [7:0]                 paddr,
  output logic [31:0]                pwdata,
  input  wire logic [31:0]           prdata,
  input  wire logic                  pready,
  input  wire logic                  pslverr,
  output backlight_pkg::amb_sample_t amb_sample
);
  import backlight_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    amb_sample = '0;
  end
  // no cycle count assumed: waits on pready, the bench timeout cuts a hang
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= idx << ADDR_SHIFT;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus shows no stale value
    paddr <= ~paddr;
    pwdata <= ~wd;
  endtask
  task automatic feed(input logic [3:0] lvl, input int cnt);
    repeat (cnt) begin
      @(posedge pclk);
      amb_sample <= '{valid: 1'b1, level: lvl};
    end
    @(posedge pclk);
    amb_sample <= '{valid: 1'b0, level: ~lvl};
  endtask
endmodule // host_model

// *** bench/keypad_backlight_control_tb.sv ***
// self-checking bench for the keypad backlight control block
`timescale 1ns/1ps
module keypad_backlight_control_tb;
  import backlight_pkg::*;
  localparam int PER = 160;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, key_light, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d, rs = 32'd59;
  amb_sample_t amb_sample;
  int          error_cnt = 0, checks = 0, cyc = 0, n;
  logic [3:0]  thr, hys, a, b;
  logic [7:0]  rst_idx [6] = '{IDX_ONOFF, IDX_DIMCTL, IDX_LDOPGM, IDX_KEYPWM, IDX_KEYTHR, IDX_AMBLEVEL};
  logic [31:0] rst_val [6] = '{32'h00, 32'h26, 32'h6c, 32'h00, 32'ha3, 32'h00};
  logic [3:0]  codes [5];
  always #2.5 pclk = ~pclk;
  // ****************************************************
  // design and host model
  // ****************************************************
  keypad_backlight_control #(.PWM_PERIOD(PER)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .amb_sample(amb_sample),
    .key_light(key_light));
  host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .amb_sample(amb_sample));
  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic int on_time(input logic [3:0] c);
    return (int'(c) + 1) * PER / 16;
  endfunction
  function automatic logic [31:0] avg2(input logic [3:0] x, input logic [3:0] y);
    return 32'((8 * int'(x) + 8 * int'(y)) >> 4);
  endfunction
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_word({31'h0, got}, {31'h0, exp}, m);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    i_host.xfer(1'b1, i, v, d, err);
  endtask
  task automatic rd(input logic [7:0] i);
    i_host.xfer(1'b0, i, 32'h0, d, err);
  endtask
  task automatic settle();
    repeat (8) @(negedge pclk);
  endtask
  task automatic amb(input logic [3:0] l);
    i_host.feed(l, 16);
    settle();
  endtask
  task automatic count_on();
    n = 0;
    repeat (PER) @(negedge pclk) if (key_light === 1'b1) n++;
  endtask
  task automatic end_test(input string t);
    $display("test %s done", t);
  endtask
  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, well above the roughly eleven thousand cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      final_report();
    end
  end
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(rst_idx[i]);
      chk_word(d, rst_val[i], "reset value");
    end
    settle();
    rd(IDX_STATUS);
    // both ambient bits clear after reset: the light stays off
    chk_word(d, {29'h0, 1'b0, SRC_NONE}, "reset source");
    chk_bit(key_light, 1'b0, "reset light");
    rd(8'h20);
    chk_word({d[30:0], err}, 32'h1, "unmapped read");
    wr(IDX_AMBLEVEL, 32'h5);
    rd(IDX_AMBLEVEL);
    chk_word(d, 32'h0, "level read only");
    end_test("reset");
    wr(IDX_ONOFF, 32'h01);
    settle();
    chk_bit(key_light, 1'b1, "host default on");
    wr(IDX_DIMCTL, 32'h06);
    settle();
    chk_bit(key_light, 1'b0, "host off");
    rd(IDX_STATUS);
    chk_word(d, {30'h0, SRC_NONE}, "no source");
    wr(IDX_DIMCTL, 32'h26);
    for (int m = 1; m < 3; m++) begin
      wr(IDX_ONOFF, 32'(m));
      settle();
      rd(IDX_STATUS);
      chk_word(d, {29'h0, 1'b1, SRC_HOST}, "one ambient bit");
    end
    end_test("host");
    wr(IDX_ONOFF, 32'h03);
    for (int k = 0; k < 3; k++) begin
      rs = xs(rs);
      thr = (k == 0) ? 4'ha : {1'b1, rs[2:0]};
      hys = (k == 0) ? 4'h3 : {2'b00, rs[5:4]};
      a = rs[11:8];
      b = rs[15:12];
      wr(IDX_KEYTHR, {24'h0, thr, hys});
      rd(IDX_KEYTHR);
      chk_word(d, {24'h0, thr, hys}, "threshold readback");
      // eight plus eight keeps the sixteen-sample window aligned
      i_host.feed(a, 8);
      i_host.feed(b, 8);
      settle();
      rd(IDX_AMBLEVEL);
      chk_word(d, avg2(a, b), "average level");
      amb(thr);
      chk_bit(key_light, 1'b0, "off at threshold");
      amb(thr - hys);
      chk_bit(key_light, 1'b0, "held in band");
      amb(thr - hys - 4'h1);
      chk_bit(key_light, 1'b1, "on below band");
      wr(IDX_DIMCTL, 32'h06);
      amb(thr - 4'h1);
      chk_bit(key_light, 1'b1, "held on, host off");
      rd(IDX_STATUS);
      chk_word(d, {29'h0, 1'b1, SRC_AMBIENT}, "ambient source");
      wr(IDX_DIMCTL, 32'h26);
    end
    end_test("ambient");
    wr(IDX_ONOFF, 32'h01);
    wr(IDX_LDOPGM, 32'h6d);
    rs = xs(rs);
    codes = '{4'h0, 4'h7, 4'hf, rs[3:0], rs[7:4]};
    foreach (codes[i]) begin
      wr(IDX_KEYPWM, {28'h0, codes[i]});
      repeat (3 * PER) @(negedge pclk);
      count_on();
      chk_word(32'(n), 32'(on_time(codes[i])), "duty on-time");
    end
    rd(IDX_STATUS);
    chk_word(d & 32'h3, {30'h0, SRC_PWM}, "pwm source");
    wr(IDX_KEYPWM, 32'h07);
    do @(negedge pclk); while (key_light !== 1'b0);
    do @(negedge pclk); while (key_light !== 1'b1);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (key_light === 1'b1 && n < 2 * PER);
    do begin
      @(negedge pclk);
      n++;
    end while (key_light !== 1'b1 && n < 2 * PER);
    chk_word(32'(n), 32'(PER), "pwm period");
    end_test("pwm");
    wr(IDX_LDOPGM, 32'h6c);
    wr(IDX_KEYPWM, 32'h37);
    repeat (2 * PER) @(negedge pclk);
    wr(IDX_LDOPGM, 32'h6d);
    repeat (PER) @(negedge pclk);
    count_on();
    chk_bit(n < on_time(4'h7), 1'b1, "fade starts low");
    repeat (36 * PER) @(negedge pclk);
    count_on();
    chk_word(32'(n), 32'(on_time(4'h7)), "fade reaches duty");
    end_test("fade");
    final_report();
  end
endmodule // keypad_backlight_control_tb

// *** design/backlight_pkg.sv ***
// constants, register map and types for the keypad backlight control block
// Behaviour
// - three exclusive sources drive the keypad light
// - ambient link bit enables ambient keypad control
// - pwm enable bit enables pwm keypad control
// - host enable bit enables host on/off control
// - turn-off threshold register, reset level ah
// - hysteresis width in same register, reset 3h
// - off at threshold, on at threshold-hysteresis-1
// - ambient plus link overrides pwm and host
// - one bit set: pwm/host; none: off
// - pwm repeats at fixed 500 hz
// - sixteen duty settings from duty code
// - duty ramps on, time from fade bits; when pwm control ends the light switches at once
// - no source after reset: both ambient bits clear, light off
// - keypad light output is one bit
// - sixteen ambient readings averaged into level register
package backlight_pkg;

  // ****************************************************
  // register indices (byte address is four times these)
  // ****************************************************
  localparam logic [7:0] IDX_ONOFF    = 8'h00;
  localparam logic [7:0] IDX_DIMCTL   = 8'h02;
  localparam logic [7:0] IDX_LDOPGM   = 8'h03;
  localparam logic [7:0] IDX_AMBLEVEL = 8'h0d;
  localparam logic [7:0] IDX_KEYPWM   = 8'h0e;
  localparam logic [7:0] IDX_KEYTHR   = 8'h0f;
  localparam logic [7:0] IDX_STATUS   = 8'h10;
  localparam int         ADDR_SHIFT   = 2;

  // ****************************************************
  // field positions and reset values
  // ****************************************************
  localparam int         BIT_AMB_EN    = 0;
  localparam int         BIT_ALC_LINK  = 1;
  localparam int         BIT_HOST_EN   = 5;
  localparam int         BIT_PWM_EN    = 0;
  localparam int         BIT_FADE_1    = 4;
  localparam int         BIT_FADE_2    = 5;
  localparam int         DUTY_LSB      = 0;
  localparam int         HYST_LSB      = 0;
  localparam int         THR_LSB       = 4;
  localparam logic [7:0] RST_ONOFF     = 8'h00;
  localparam logic [7:0] RST_DIMCTL    = 8'h26;
  localparam logic [7:0] RST_LDOPGM    = 8'h6c;
  localparam logic [7:0] RST_KEYPWM    = 8'h00;
  localparam logic [3:0] RST_THRESHOLD = 4'ha;
  localparam logic [3:0] RST_HYSTERESIS = 4'h3;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int         CLK_HZ        = 200_000_000;
  localparam int         PWM_FREQ_HZ   = 500;
  localparam int         PWM_PERIOD_CYCLES = CLK_HZ / PWM_FREQ_HZ;
  localparam int         DUTY_STEPS    = 16;
  localparam logic [3:0] SAMPLES_LAST  = 4'hf;
  localparam int         AVG_SHIFT     = 4;

  typedef enum logic [1:0] {
    SRC_NONE    = 2'b00,
    SRC_AMBIENT = 2'b01,
    SRC_PWM     = 2'b10,
    SRC_HOST    = 2'b11
  } source_t;

  typedef enum logic {
    AMB_LIT  = 1'b0,
    AMB_DARK = 1'b1
  } amb_state_t;

  typedef struct packed {
    logic [3:0] duty_code;
    logic [1:0] fade_select;
  } pwm_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] level;
  } amb_sample_t;

endpackage

// *** design/keypad_backlight_control.sv ***
// keypad backlight source selection, ambient hysteresis and apb registers
`timescale 1ns/1ps
module keypad_backlight_control #(
  parameter int PWM_PERIOD = backlight_pkg::PWM_PERIOD_CYCLES
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire backlight_pkg::amb_sample_t amb_sample,
  output logic                           key_light
);
  import backlight_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  logic [7:0]  reg_onoff;
  logic [7:0]  reg_dimctl;
  logic [7:0]  reg_ldopgm;
  logic [7:0]  reg_keypwm;
  logic [3:0]  threshold;
  logic [3:0]  hysteresis;
  logic [3:0]  amb_level;
  logic [7:0]  amb_acc;
  logic [3:0]  amb_cnt;
  amb_state_t  amb_state;
  source_t     source;

  logic [7:0]  next_onoff;
  logic [7:0]  next_dimctl;
  logic [7:0]  next_ldopgm;
  logic [7:0]  next_keypwm;
  logic [3:0]  next_threshold;
  logic [3:0]  next_hysteresis;
  logic [3:0]  next_amb_level;
  logic [7:0]  next_amb_acc;
  logic [3:0]  next_amb_cnt;
  amb_state_t  next_amb_state;
  source_t     next_source;
  logic        next_key_light;
  logic [31:0] next_prdata;

  logic [7:0]  index;
  logic        hit;
  logic [31:0] rd_word;
  logic        wr_en;
  logic [8:0]  amb_sum;
  logic [5:0]  on_limit;
  logic        amb_en;
  logic        alc_link;
  logic        pwm_en;
  logic        host_en;
  logic        pwm_wave;
  pwm_cfg_t    pwm_cfg;

  // ****************************************************
  // apb decode
  // ****************************************************
  // unaligned low address bits are ignored; one word per register
  always_comb begin
    index   = {2'b00, paddr[7:ADDR_SHIFT]};
    hit     = 1'b1;
    rd_word = 32'h00000000;
    if (index == IDX_ONOFF) begin
      rd_word[7:0] = reg_onoff;
    end else if (index == IDX_DIMCTL) begin
      rd_word[7:0] = reg_dimctl;
    end else if (index == IDX_LDOPGM) begin
      rd_word[7:0] = reg_ldopgm;
    end else if (index == IDX_AMBLEVEL) begin
      rd_word[3:0] = amb_level;
    end else if (index == IDX_KEYPWM) begin
      rd_word[7:0] = reg_keypwm;
    end else if (index == IDX_KEYTHR) begin
      rd_word[7:0] = {threshold, hysteresis};
    end else if (index == IDX_STATUS) begin
      rd_word[2:0] = {key_light, source};
    end else begin
      hit = 1'b0;
    end
  end

  // no wait states: read data is latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite && hit;

  // ****************************************************
  // register writes
  // ****************************************************
  always_comb begin
    next_onoff      = reg_onoff;
    next_dimctl     = reg_dimctl;
    next_ldopgm     = reg_ldopgm;
    next_keypwm     = reg_keypwm;
    next_threshold  = threshold;
    next_hysteresis = hysteresis;
    next_prdata     = prdata;
    if (psel && !penable && !pwrite) begin
      next_prdata = rd_word;
    end
    if (wr_en) begin
      if (index == IDX_ONOFF) begin
        next_onoff = pwdata[7:0];
      end else if (index == IDX_DIMCTL) begin
        next_dimctl = pwdata[7:0];
      end else if (index == IDX_LDOPGM) begin
        next_ldopgm = pwdata[7:0];
      end else if (index == IDX_KEYPWM) begin
        next_keypwm = pwdata[7:0];
      end else if (index == IDX_KEYTHR) begin
        next_threshold  = pwdata[THR_LSB +: 4];
        next_hysteresis = pwdata[HYST_LSB +: 4];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_onoff  <= RST_ONOFF;
      reg_dimctl <= RST_DIMCTL;
      reg_ldopgm <= RST_LDOPGM;
      reg_keypwm <= RST_KEYPWM;
      threshold  <= RST_THRESHOLD;
      hysteresis <= RST_HYSTERESIS;
      prdata     <= 32'h00000000;
    end else begin
      reg_onoff  <= next_onoff;
      reg_dimctl <= next_dimctl;
      reg_ldopgm <= next_ldopgm;
      reg_keypwm <= next_keypwm;
      threshold  <= next_threshold;
      hysteresis <= next_hysteresis;
      prdata     <= next_prdata;
    end
  end

  // ****************************************************
  // ambient averaging and hysteresis
  // ****************************************************
  always_comb begin
    amb_sum        = {1'b0, amb_acc} + {5'h00, amb_sample.level};
    next_amb_acc   = amb_acc;
    next_amb_cnt   = amb_cnt;
    next_amb_level = amb_level;
    if (amb_sample.valid) begin
      if (amb_cnt == SAMPLES_LAST) begin
        next_amb_level = amb_sum[AVG_SHIFT +: 4];
        next_amb_acc   = 8'h00;
        next_amb_cnt   = 4'h0;
      end else begin
        next_amb_acc = amb_sum[7:0];
        next_amb_cnt = amb_cnt + 4'h1;
      end
    end
    // negative limit means the light never comes back on
    on_limit       = {2'b00, threshold} - {2'b00, hysteresis} - 6'h01;
    next_amb_state = amb_state;
    case (amb_state)
      AMB_LIT: begin
        if (amb_level >= threshold) begin
          next_amb_state = AMB_DARK;
        end
      end
      AMB_DARK: begin
        if (!on_limit[5] && ({2'b00, amb_level} <= on_limit)) begin
          next_amb_state = AMB_LIT;
        end
      end
      default: next_amb_state = AMB_LIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amb_acc   <= 8'h00;
      amb_cnt   <= 4'h0;
      amb_level <= 4'h0;
      amb_state <= AMB_LIT;
    end else begin
      amb_acc   <= next_amb_acc;
      amb_cnt   <= next_amb_cnt;
      amb_level <= next_amb_level;
      amb_state <= next_amb_state;
    end
  end

  // ****************************************************
  // source selection and output
  // ****************************************************
  assign amb_en   = reg_onoff[BIT_AMB_EN];
  assign alc_link = reg_onoff[BIT_ALC_LINK];
  assign pwm_en   = reg_ldopgm[BIT_PWM_EN];
  assign host_en  = reg_dimctl[BIT_HOST_EN];
  assign pwm_cfg  = '{duty_code: reg_keypwm[DUTY_LSB +: 4],
                      fade_select: {reg_keypwm[BIT_FADE_2], reg_keypwm[BIT_FADE_1]}};

  // pwm wins over host when both are set, keeping one owner at a time
  always_comb begin
    if (amb_en && alc_link) begin
      next_source = SRC_AMBIENT;
    end else if (amb_en == alc_link) begin
      next_source = SRC_NONE;
    end else if (pwm_en) begin
      next_source = SRC_PWM;
    end else if (host_en) begin
      next_source = SRC_HOST;
    end else begin
      next_source = SRC_NONE;
    end
    case (source)
      SRC_AMBIENT: next_key_light = (amb_state == AMB_LIT);
      SRC_PWM:     next_key_light = pwm_wave;
      SRC_HOST:    next_key_light = 1'b1;
      default:     next_key_light = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source    <= SRC_NONE;
      key_light <= 1'b0;
    end else begin
      source    <= next_source;
      key_light <= next_key_light;
    end
  end

  pwm_fade #(
    .PERIOD_CYCLES (PWM_PERIOD)
  ) u_pwm (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (source == SRC_PWM),
    .cfg     (pwm_cfg),
    .pwm_out (pwm_wave)
  );

  // ****************************************************
  // checks
  // ****************************************************
  sequence s_amb_mode;
    amb_en && alc_link;
  endsequence

  property p_ambient_override;
    @(posedge pclk) disable iff (!presetn)
    s_amb_mode ##1 s_amb_mode |=> (key_light == $past(amb_state == AMB_LIT));
  endproperty
  a_ambient_override: assert property (p_ambient_override) else $error("ambient not in control");

  property p_none_off;
    @(posedge pclk) disable iff (!presetn)
    (!amb_en && !alc_link) [*2] |=> !key_light;
  endproperty
  a_none_off: assert property (p_none_off) else $error("light on with both bits clear");

  property p_host_on;
    @(posedge pclk) disable iff (!presetn)
    ((amb_en != alc_link) && !pwm_en && host_en) [*2] |=> key_light;
  endproperty
  a_host_on: assert property (p_host_on) else $error("host command not obeyed");

  property p_off_at_threshold;
    @(posedge pclk) disable iff (!presetn)
    (amb_state == AMB_LIT) && (amb_level >= threshold) |=> (amb_state == AMB_DARK);
  endproperty
  a_off_at_threshold: assert property (p_off_at_threshold) else $error("no turn off at threshold");

  property p_stay_dark;
    @(posedge pclk) disable iff (!presetn)
    (amb_state == AMB_DARK) && ({2'b00, amb_level} > on_limit) && !on_limit[5]
      |=> (amb_state == AMB_DARK);
  endproperty
  a_stay_dark: assert property (p_stay_dark) else $error("turned on inside hysteresis");

  property p_average_stored;
    @(posedge pclk) disable iff (!presetn)
    amb_sample.valid && (amb_cnt == SAMPLES_LAST) |=> (amb_level == $past(amb_sum[7:4]));
  endproperty
  a_average_stored: assert property (p_average_stored) else $error("average not stored");

  property p_thr_write;
    @(posedge pclk) disable iff (!presetn)
    wr_en && (index == IDX_KEYPWM + 8'h01)
      |=> ({threshold, hysteresis} == $past(pwdata[7:0]));
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

  property p_pwm_follow;
    @(posedge pclk) disable iff (!presetn)
    (source == SRC_PWM) |=> (key_light == $past(pwm_wave));
  endproperty
  a_pwm_follow: assert property (p_pwm_follow) else $error("light not following pwm");

endmodule // keypad_backlight_control

// *** design/pwm_fade.sv ***
// 500 hz keypad pwm with sixteen duty levels and fade ramp
`timescale 1ns/1ps
module pwm_fade #(
  parameter int PERIOD_CYCLES = backlight_pkg::PWM_PERIOD_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 run,
  input  wire backlight_pkg::pwm_cfg_t cfg,
  output logic                      pwm_out
);
  import backlight_pkg::*;

  localparam logic [18:0] LAST_CNT = 19'(PERIOD_CYCLES - 1);
  localparam logic [18:0] SLOT     = 19'(PERIOD_CYCLES / DUTY_STEPS);
  localparam logic [4:0]  LEVEL_ZERO = 5'h00;
  localparam logic [4:0]  LEVEL_FULL = 5'h10;

  logic [18:0] cnt;
  logic [18:0] next_cnt;
  logic [4:0]  level;
  logic [4:0]  next_level;
  logic [1:0]  hold;
  logic [1:0]  next_hold;
  logic        next_pwm_out;
  logic [4:0]  target;
  logic [1:0]  hold_last;
  logic        period_end;

  // ****************************************************
  // period counter, fade ramp and output compare
  // ****************************************************
  always_comb begin
    period_end = (cnt == LAST_CNT);
    next_cnt   = period_end ? 19'h00000 : cnt + 19'h00001;
    target     = run ? ({1'b0, cfg.duty_code} + 5'h01) : LEVEL_ZERO;
    // periods per duty step: 1, 2 or 4; code zero means no ramp
    case (cfg.fade_select)
      2'b01:   hold_last = 2'h0;
      2'b10:   hold_last = 2'h1;
      default: hold_last = 2'h3;
    endcase
    next_level = level;
    next_hold  = hold;
    if (cfg.fade_select == 2'b00) begin
      next_level = target;
      next_hold  = 2'h0;
    end else if (period_end && (level != target)) begin
      if (hold >= hold_last) begin
        next_hold  = 2'h0;
        next_level = (level < target) ? level + 5'h01 : level - 5'h01;
      end else begin
        next_hold = hold + 2'h1;
      end
    end
    // longer code gives more slots high per period
    next_pwm_out = (cnt < 19'(level) * SLOT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= 19'h00000;
      level   <= LEVEL_ZERO;
      hold    <= 2'h0;
      pwm_out <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      level   <= next_level;
      hold    <= next_hold;
      pwm_out <= next_pwm_out;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  property p_period_wrap;
    @(posedge pclk) disable iff (!presetn)
    (cnt == LAST_CNT) |=> (cnt == 19'h00000);
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("pwm period did not wrap");

  property p_dark_level;
    @(posedge pclk) disable iff (!presetn)
    (level == LEVEL_ZERO) |=> !pwm_out;
  endproperty
  a_dark_level: assert property (p_dark_level) else $error("pwm high at level zero");

  property p_full_level;
    @(posedge pclk) disable iff (!presetn)
    (level == LEVEL_FULL) |=> pwm_out;
  endproperty
  a_full_level: assert property (p_full_level) else $error("pwm low at full level");

  property p_ramp_step;
    @(posedge pclk) disable iff (!presetn)
    (cfg.fade_select != 2'b00) && $stable(cfg.fade_select)
      |-> (level == $past(level)) || (level == $past(level) + 5'h01)
          || (level == $past(level) - 5'h01);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("fade jumped more than one step");

endmodule // pwm_fade
